/* File: logic/sgs_defs.svh */
// Register offsets, field positions, reset values and timing counts of the gain switch selector
`ifndef SGS_DEFS_SVH
`define SGS_DEFS_SVH

`define SGS_OFF_VEL_MODE 8'h00
`define SGS_OFF_VEL_DELAY 8'h04
`define SGS_OFF_VEL_LEVEL 8'h08
`define SGS_OFF_VEL_HYST 8'h0C
`define SGS_OFF_TRQ_MODE 8'h10
`define SGS_OFF_TRQ_DELAY 8'h14
`define SGS_OFF_TRQ_LEVEL 8'h18
`define SGS_OFF_TRQ_HYST 8'h1C
`define SGS_OFF_CTRL 8'h20
`define SGS_OFF_STATUS 8'h24
`define SGS_OFF_VEL_HEFF 8'h28
`define SGS_OFF_TRQ_HEFF 8'h2C

`define SGS_RST_MODE 3'h0
`define SGS_RST_VALUE 16'h0000
`define SGS_RST_ASSIGNED 1'b0

`define SGS_VEL_MODE_MAX 3'h5
`define SGS_TRQ_MODE_MAX 3'h3
`define SGS_DELAY_MAX 16'h2710
`define SGS_LEVEL_MAX 16'h4E20

`define SGS_CTRL_ASSIGNED_BIT 0
`define SGS_ST_VEL_BIT 0
`define SGS_ST_TRQ_BIT 1
`define SGS_ST_ACTIVE_BIT 2
`define SGS_ST_INPUT_BIT 3
`define SGS_ST_METHOD_LSB 4

`define SGS_CLK_PERIOD_NS 25
`define SGS_TICK_TIME_NS 100000
`define SGS_TICK_CYCLES (`SGS_TICK_TIME_NS / `SGS_CLK_PERIOD_NS)

`endif

/* File: logic/sgs_pkg.sv */
// Types shared by the gain switch selector modules
package sgs_pkg;

  // Active control method reported by the drive
  typedef enum logic [1:0] {
    SGS_METHOD_POSITION,
    SGS_METHOD_VELOCITY,
    SGS_METHOD_TORQUE,
    SGS_METHOD_OTHER
  } sgs_method_e;

  // How one loop chooses its gain set
  typedef enum logic [1:0] {
    SGS_KIND_FIRST,
    SGS_KIND_SECOND,
    SGS_KIND_INPUT,
    SGS_KIND_COMPARE
  } sgs_kind_e;

endpackage : sgs_pkg

/* File: logic/sgs_eval_if.sv */
// Settings and result passed between the selector top and one loop evaluator
`timescale 1ns/10ps
interface sgs_eval_if;
  import sgs_pkg::*;
  logic enable;
  sgs_kind_e kind;
  logic sel_in;
  logic [15:0] mag;
  logic [15:0] level;
  logic [15:0] hyst;
  logic [15:0] delay;
  logic second;

  modport top
  (
    output enable,
    output kind,
    output sel_in,
    output mag,
    output level,
    output hyst,
    output delay,
    input second
  );

  modport eval
  (
    input enable,
    input kind,
    input sel_in,
    input mag,
    input level,
    input hyst,
    input delay,
    output second
  );
endinterface : sgs_eval_if

/* File: logic/sgs_tick_gen.sv */
// Periodic control tick generator
`timescale 1ns/10ps
module sgs_tick_gen
#(
  parameter int CYCLES = 4000
)
(
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  logic [15:0] cnt_r;

  // Count one tick period and pulse at its end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end
    else if (cnt_r == 16'(CYCLES - 1))
    begin
      cnt_r <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule : sgs_tick_gen

/* File: logic/sgs_switch_eval.sv */
// One loop's gain set decision: fixed, input driven or level compare with return delay
`timescale 1ns/10ps
module sgs_switch_eval
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  sgs_eval_if.eval ev
);
  import sgs_pkg::*;

  logic second_r;
  logic [15:0] cnt_r;
  logic [16:0] upper;
  logic [16:0] lower;
  logic [16:0] mag_w;

  // Thresholds; hysteresis arrives already limited to the level
  assign upper = {1'b0, ev.level} + {1'b0, ev.hyst};
  assign lower = {1'b0, ev.level} - {1'b0, ev.hyst};
  assign mag_w = {1'b0, ev.mag};
  assign ev.second = second_r;

  // Decision and delay count, evaluated once per control tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      second_r <= 1'b0;
      cnt_r <= 16'h0000;
    end
    else if (tick)
    begin
      if (!ev.enable)
      begin
        second_r <= 1'b0; // RULE_07 RULE_10
        cnt_r <= 16'h0000;
      end
      else
      begin
        case (ev.kind)
          SGS_KIND_FIRST:
          begin
            second_r <= 1'b0; // RULE_02
            cnt_r <= 16'h0000;
          end
          SGS_KIND_SECOND:
          begin
            second_r <= 1'b1; // RULE_02
            cnt_r <= 16'h0000;
          end
          SGS_KIND_INPUT:
          begin
            second_r <= ev.sel_in; // RULE_03 RULE_17
            cnt_r <= 16'h0000;
          end
          SGS_KIND_COMPARE:
          begin
            if (!second_r)
            begin
              second_r <= (mag_w > upper); // RULE_05 RULE_08
              cnt_r <= 16'h0000;
            end
            else if (mag_w < lower)
            begin
              if (cnt_r >= ev.delay)
              begin
                second_r <= 1'b0; // RULE_06 RULE_09 RULE_11 RULE_18
                cnt_r <= 16'h0000;
              end
              else
              begin
                cnt_r <= cnt_r + 16'h0001; // RULE_20
              end
            end
            else
            begin
              cnt_r <= 16'h0000; // RULE_20
            end
          end
          default:
          begin
            second_r <= 1'b0;
            cnt_r <= 16'h0000;
          end
        endcase
      end
    end
  end
endmodule : sgs_switch_eval

/* File: logic/sgs_gain_switch_selector.sv */
// Gain switch selector top: APB registers, input sync, mode decode and the two loop evaluators
//
// Contract
// RULE_01 - Velocity mode 0..5, default 0, velocity only
// RULE_02 - Setting 0 fixes first, 1 fixes second
// RULE_03 - Mode 2: open first, common return second
// RULE_04 - Mode 2 unassigned input keeps first set
// RULE_05 - Mode 3: torque above level+hysteresis goes second
// RULE_06 - Mode 3: below level-hysteresis for delay returns
// RULE_07 - Torque compare acts only under velocity control
// RULE_08 - Mode 4: command change above threshold goes second
// RULE_09 - Mode 4: below lower threshold for delay returns
// RULE_10 - Command change mode forces first outside velocity
// RULE_11 - Velocity delay 0..10000 ticks, default 0
// RULE_12 - Velocity level 0..20000, default 0
// RULE_13 - Velocity hysteresis 0..20000, default 0
// RULE_14 - Hysteresis above level is limited to level
// RULE_15 - Software should keep level at least hysteresis
// RULE_16 - Torque mode 0..3, default 0, torque only
// RULE_17 - Input closed selects second in either method
// RULE_18 - Torque delay 0..10000 ticks, default 0
// RULE_19 - Torque level, hysteresis 0..20000, default 0
// RULE_20 - Evaluate per 0.1 ms tick, restart delay
// RULE_21 - Unlisted mode value keeps first set
`timescale 1ns/10ps
`include "sgs_defs.svh"
module sgs_gain_switch_selector
#(
  parameter int TICK_CYCLES = `SGS_TICK_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gain_sel_closed,
  input wire sgs_pkg::sgs_method_e ctrl_method,
  input wire logic signed [15:0] torque_cmd,
  input wire logic signed [15:0] speed_cmd_rate,
  input wire logic signed [15:0] motor_speed,
  output logic vel_gain_second,
  output logic trq_gain_second,
  output logic gain_second
);
  import sgs_pkg::*;

  logic [2:0] vel_mode_r;
  logic [15:0] vel_delay_r;
  logic [15:0] vel_level_r;
  logic [15:0] vel_hyst_r;
  logic [2:0] trq_mode_r;
  logic [15:0] trq_delay_r;
  logic [15:0] trq_level_r;
  logic [15:0] trq_hyst_r;
  logic assigned_r;
  logic sync1_r;
  logic sync2_r;
  logic [15:0] vel_heff;
  logic [15:0] trq_heff;
  logic tick;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic [31:0] rd_val;
  logic [15:0] wval;
  sgs_eval_if vel_if ();
  sgs_eval_if trq_if ();

  // Magnitude of a signed command; the most negative value maps to 16'h8000
  function automatic logic [15:0] sgs_abs(input logic signed [15:0] v);
    sgs_abs = v[15] ? 16'(-v) : 16'(v);
  endfunction : sgs_abs

  // Limit a written value to its top of range
  function automatic logic [15:0] sgs_clip(input logic [15:0] v, input logic [15:0] max);
    sgs_clip = (v > max) ? max : v;
  endfunction : sgs_clip

  // Mode value to decision kind; values beyond the loop's range fall back to first set
  function automatic sgs_kind_e sgs_kind(input logic [2:0] mode, input logic [2:0] max);
    if (mode > max)
      sgs_kind = SGS_KIND_FIRST; // RULE_21
    else if (mode == 3'h0)
      sgs_kind = SGS_KIND_FIRST;
    else if (mode == 3'h1)
      sgs_kind = SGS_KIND_SECOND;
    else if (mode == 3'h2)
      sgs_kind = SGS_KIND_INPUT;
    else
      sgs_kind = SGS_KIND_COMPARE;
  endfunction : sgs_kind

  // APB strobes: write commits in the access cycle that sees pready high
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable;
  assign wval = pwdata[15:0];

  // Two flip-flop synchroniser for the gain-select pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end
    else
    begin
      sync1_r <= gain_sel_closed;
      sync2_r <= sync1_r;
    end
  end

  // Velocity loop settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vel_mode_r <= `SGS_RST_MODE; // RULE_01
      vel_delay_r <= `SGS_RST_VALUE; // RULE_11
      vel_level_r <= `SGS_RST_VALUE; // RULE_12
      vel_hyst_r <= `SGS_RST_VALUE; // RULE_13
    end
    else if (wr_en)
    begin
      case (paddr)
        `SGS_OFF_VEL_MODE: vel_mode_r <= pwdata[2:0]; // RULE_01
        `SGS_OFF_VEL_DELAY: vel_delay_r <= sgs_clip(wval, `SGS_DELAY_MAX); // RULE_11
        `SGS_OFF_VEL_LEVEL: vel_level_r <= sgs_clip(wval, `SGS_LEVEL_MAX); // RULE_12
        `SGS_OFF_VEL_HYST: vel_hyst_r <= sgs_clip(wval, `SGS_LEVEL_MAX); // RULE_13
        default:
        begin
        end
      endcase
    end
  end

  // Torque loop settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trq_mode_r <= `SGS_RST_MODE; // RULE_16
      trq_delay_r <= `SGS_RST_VALUE; // RULE_18
      trq_level_r <= `SGS_RST_VALUE; // RULE_19
      trq_hyst_r <= `SGS_RST_VALUE; // RULE_19
    end
    else if (wr_en)
    begin
      case (paddr)
        `SGS_OFF_TRQ_MODE: trq_mode_r <= pwdata[2:0]; // RULE_16
        `SGS_OFF_TRQ_DELAY: trq_delay_r <= sgs_clip(wval, `SGS_DELAY_MAX); // RULE_18
        `SGS_OFF_TRQ_LEVEL: trq_level_r <= sgs_clip(wval, `SGS_LEVEL_MAX); // RULE_19
        `SGS_OFF_TRQ_HYST: trq_hyst_r <= sgs_clip(wval, `SGS_LEVEL_MAX); // RULE_19
        default:
        begin
        end
      endcase
    end
  end

  // Control register: whether a pin is allocated to the gain-select function
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      assigned_r <= `SGS_RST_ASSIGNED;
    else if (wr_en && paddr == `SGS_OFF_CTRL)
      assigned_r <= pwdata[`SGS_CTRL_ASSIGNED_BIT];
  end

  // Effective hysteresis never exceeds the level
  assign vel_heff = (vel_level_r < vel_hyst_r) ? vel_level_r : vel_hyst_r; // RULE_14 RULE_15
  assign trq_heff = (trq_level_r < trq_hyst_r) ? trq_level_r : trq_hyst_r; // RULE_14 RULE_15

  // Velocity evaluator drive; compare source depends on the mode
  assign vel_if.enable = (ctrl_method == SGS_METHOD_VELOCITY); // RULE_01 RULE_07 RULE_10
  assign vel_if.kind = sgs_kind(vel_mode_r, `SGS_VEL_MODE_MAX); // RULE_01 RULE_21
  assign vel_if.sel_in = assigned_r & sync2_r; // RULE_03 RULE_04
  assign vel_if.level = vel_level_r; // RULE_12
  assign vel_if.hyst = vel_heff; // RULE_13
  assign vel_if.delay = vel_delay_r; // RULE_11

  // Velocity compare magnitude: torque, command change or actual speed
  always_comb
  begin
    case (vel_mode_r)
      3'h3: vel_if.mag = sgs_abs(torque_cmd); // RULE_05
      3'h4: vel_if.mag = sgs_abs(speed_cmd_rate); // RULE_08
      3'h5: vel_if.mag = sgs_abs(motor_speed);
      default: vel_if.mag = 16'h0000;
    endcase
  end

  // Torque evaluator drive; only the torque command is compared
  assign trq_if.enable = (ctrl_method == SGS_METHOD_TORQUE); // RULE_16
  assign trq_if.kind = sgs_kind(trq_mode_r, `SGS_TRQ_MODE_MAX); // RULE_16 RULE_21
  assign trq_if.sel_in = assigned_r & sync2_r; // RULE_04 RULE_17
  assign trq_if.mag = sgs_abs(torque_cmd); // RULE_05
  assign trq_if.level = trq_level_r; // RULE_19
  assign trq_if.hyst = trq_heff; // RULE_19
  assign trq_if.delay = trq_delay_r; // RULE_18

  // Control tick source
  sgs_tick_gen #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick) // RULE_20
  );

  // Velocity loop decision
  sgs_switch_eval u_vel (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .ev(vel_if)
  );

  // Torque loop decision
  sgs_switch_eval u_trq (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .ev(trq_if)
  );

  // Registered gain outputs; the active one follows the control method
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vel_gain_second <= 1'b0;
      trq_gain_second <= 1'b0;
      gain_second <= 1'b0;
    end
    else
    begin
      vel_gain_second <= vel_if.second;
      trq_gain_second <= trq_if.second;
      if (ctrl_method == SGS_METHOD_VELOCITY)
        gain_second <= vel_if.second;
      else if (ctrl_method == SGS_METHOD_TORQUE)
        gain_second <= trq_if.second;
      else
        gain_second <= 1'b0;
    end
  end

  // Read mux and address decode
  always_comb
  begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `SGS_OFF_VEL_MODE: rd_val[2:0] = vel_mode_r;
      `SGS_OFF_VEL_DELAY: rd_val[15:0] = vel_delay_r;
      `SGS_OFF_VEL_LEVEL: rd_val[15:0] = vel_level_r;
      `SGS_OFF_VEL_HYST: rd_val[15:0] = vel_hyst_r;
      `SGS_OFF_TRQ_MODE: rd_val[2:0] = trq_mode_r;
      `SGS_OFF_TRQ_DELAY: rd_val[15:0] = trq_delay_r;
      `SGS_OFF_TRQ_LEVEL: rd_val[15:0] = trq_level_r;
      `SGS_OFF_TRQ_HYST: rd_val[15:0] = trq_hyst_r;
      `SGS_OFF_CTRL: rd_val[`SGS_CTRL_ASSIGNED_BIT] = assigned_r;
      `SGS_OFF_STATUS:
      begin
        rd_val[`SGS_ST_VEL_BIT] = vel_gain_second;
        rd_val[`SGS_ST_TRQ_BIT] = trq_gain_second;
        rd_val[`SGS_ST_ACTIVE_BIT] = gain_second;
        rd_val[`SGS_ST_INPUT_BIT] = sync2_r;
        rd_val[`SGS_ST_METHOD_LSB +: 2] = ctrl_method;
      end
      `SGS_OFF_VEL_HEFF: rd_val[15:0] = vel_heff;
      `SGS_OFF_TRQ_HEFF: rd_val[15:0] = trq_heff;
      default: mapped = 1'b0;
    endcase
  end

  // APB answer: data and error captured in setup, pready high for one access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= rd_setup;
      if (rd_setup)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr <= ~mapped;
      end
      else
      begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule : sgs_gain_switch_selector

/* File: verif/sgs_gain_switch_selector_monitor.sv */
// Port checker for the gain switch selector, bound into its top module
`timescale 1ns/10ps
module sgs_gain_switch_selector_monitor
#(
  parameter int TICK_CYCLES = 4000
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic gain_sel_closed,
  input wire sgs_pkg::sgs_method_e ctrl_method,
  input wire logic signed [15:0] torque_cmd,
  input wire logic signed [15:0] speed_cmd_rate,
  input wire logic signed [15:0] motor_speed,
  input wire logic vel_gain_second,
  input wire logic trq_gain_second,
  input wire logic gain_second
);
  import sgs_pkg::*;
  logic [15:0] nv_r;
  logic [15:0] nt_r;
  logic setup;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign setup = psel && !penable;

  // Edges spent outside velocity and outside torque control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nv_r <= 16'h0;
      nt_r <= 16'h0;
    end
    else
    begin
      nv_r <= (ctrl_method == SGS_METHOD_VELOCITY) ? 16'h0 : nv_r + {15'h0, nv_r != 16'hFFFF};
      nt_r <= (ctrl_method == SGS_METHOD_TORQUE) ? 16'h0 : nt_r + {15'h0, nt_r != 16'hFFFF};
    end
  end

  a_ready_after_setup: assert property (setup |=> pready) else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
  a_ready_no_setup: assert property (!setup |=> !pready) else $error("ready without setup");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_err_unmapped: assert property (setup && paddr > 8'h2C |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (setup && paddr <= 8'h2C && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  a_rdata_holds: assert property (!setup |=> $stable(prdata)) else $error("read data moved");
  a_vel_off_method: assert property (nv_r > TICK_CYCLES + 3 |-> !vel_gain_second)
    else $error("velocity loop second outside velocity control");
  a_trq_off_method: assert property (nt_r > TICK_CYCLES + 3 |-> !trq_gain_second)
    else $error("torque loop second outside torque control");
  a_gain_idle_method: assert property ((ctrl_method == SGS_METHOD_POSITION) [*3] |-> !gain_second)
    else $error("gain second under position control");
  a_gain_tracks_vel: assert property ((ctrl_method == SGS_METHOD_VELOCITY) [*3] |-> gain_second == vel_gain_second)
    else $error("gain second differs from velocity loop");

  // Main scenarios reached
  c_vel_second: cover property ($rose(vel_gain_second));
  c_trq_second: cover property ($rose(trq_gain_second));
  c_gain_second: cover property ($rose(gain_second));
  c_refused: cover property (pslverr);
endmodule : sgs_gain_switch_selector_monitor

bind sgs_gain_switch_selector sgs_gain_switch_selector_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon
(
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gain_sel_closed(gain_sel_closed),
  .ctrl_method(ctrl_method), .torque_cmd(torque_cmd), .speed_cmd_rate(speed_cmd_rate),
  .motor_speed(motor_speed), .vel_gain_second(vel_gain_second), .trq_gain_second(trq_gain_second),
  .gain_second(gain_second)
);

/* File: verif/sgs_host_model.sv */
// Host controller model driving the gain-select pin
`timescale 1ns/10ps
module sgs_host_model
(
  input wire logic pclk,
  input wire logic close_req,
  output logic gain_sel_closed
);
  initial gain_sel_closed = 1'b0;

  // Pin follows the host request one cycle late, with no tick alignment
  always @(posedge pclk)
  begin
    gain_sel_closed <= close_req;
  end
endmodule : sgs_host_model

/* File: verif/sgs_testbench.sv */
// Self-checking testbench of the gain switch selector
`timescale 1ns/10ps
`include "sgs_defs.svh"
module testbench;
  import sgs_pkg::*;
  localparam int T = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, close_req = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, rerr, gain_sel_closed, vel_gain_second, trq_gain_second, gain_second;
  sgs_method_e ctrl_method = SGS_METHOD_POSITION;
  logic signed [15:0] torque_cmd = 16'sh0, speed_cmd_rate = 16'sh0, motor_speed = 16'sh0;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

  sgs_gain_switch_selector #(.TICK_CYCLES(T)) uut
  (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gain_sel_closed(gain_sel_closed),
    .ctrl_method(ctrl_method), .torque_cmd(torque_cmd), .speed_cmd_rate(speed_cmd_rate),
    .motor_speed(motor_speed), .vel_gain_second(vel_gain_second), .trq_gain_second(trq_gain_second),
    .gain_second(gain_second)
  );
  sgs_host_model u_host (.pclk(pclk), .close_req(close_req), .gain_sel_closed(gain_sel_closed));

  // Clock of 25 ns
  initial forever #12.5 pclk = ~pclk;

  // Hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  // One APB transfer; holds the request until ready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rdata, e);
  endtask : rd_chk

  task automatic chk_out(input logic v, input logic t, input logic g);
    chk({29'h0, vel_gain_second, trq_gain_second, gain_second}, {29'h0, v, t, g});
  endtask : chk_out

  // Reset values, clipping and an unmapped address
  task automatic t_regs;
    for (int a = 0; a < 12; a++) rd_chk(8'(a * 4), 32'h0);
    wr(`SGS_OFF_VEL_DELAY, 32'hFFFF);
    rd_chk(`SGS_OFF_VEL_DELAY, 32'h2710);
    wr(`SGS_OFF_VEL_HYST, 32'h4E21);
    rd_chk(`SGS_OFF_VEL_HYST, 32'h4E20);
    wr(`SGS_OFF_TRQ_LEVEL, 32'hFFFF);
    rd_chk(`SGS_OFF_TRQ_LEVEL, 32'h4E20);
    wr(`SGS_OFF_TRQ_DELAY, 32'h2711);
    rd_chk(`SGS_OFF_TRQ_DELAY, 32'h2710);
    apb(8'h30, 1'b0, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdata, 32'h0);
    wr(`SGS_OFF_VEL_DELAY, 32'h0);
    wr(`SGS_OFF_VEL_HYST, 32'h0);
    wr(`SGS_OFF_TRQ_LEVEL, 32'h0);
  endtask : t_regs

  // Every mode code in velocity, torque and position control
  task automatic t_modes;
    torque_cmd <= 16'sd5;
    speed_cmd_rate <= 16'sd5;
    motor_speed <= 16'sd5;
    for (int m = 0; m < 8; m++)
    begin
      wr(`SGS_OFF_VEL_MODE, 32'(m));
      wr(`SGS_OFF_TRQ_MODE, 32'(m));
      ctrl_method <= SGS_METHOD_VELOCITY;
      wt(2 * T);
      chk_out((m == 1) || (m >= 3 && m <= 5), 1'b0, (m == 1) || (m >= 3 && m <= 5));
      ctrl_method <= SGS_METHOD_TORQUE;
      wt(2 * T);
      chk_out(1'b0, (m == 1) || (m == 3), (m == 1) || (m == 3));
      ctrl_method <= SGS_METHOD_POSITION;
      wt(2 * T);
      chk_out(1'b0, 1'b0, 1'b0);
    end
    torque_cmd <= 16'sd0;
    speed_cmd_rate <= 16'sd0;
    motor_speed <= 16'sd0;
  endtask : t_modes

  // Gain-select pin with and without assignment
  task automatic t_input;
    wr(`SGS_OFF_VEL_MODE, 32'h2);
    wr(`SGS_OFF_TRQ_MODE, 32'h2);
    ctrl_method <= SGS_METHOD_VELOCITY;
    close_req <= 1'b1;
    wt(2 * T);
    chk_out(1'b0, 1'b0, 1'b0);
    wr(`SGS_OFF_CTRL, 32'h1);
    wt(2 * T);
    chk_out(1'b1, 1'b0, 1'b1);
    rd_chk(`SGS_OFF_STATUS, 32'h0000_001D);
    ctrl_method <= SGS_METHOD_TORQUE;
    wt(2 * T);
    chk_out(1'b0, 1'b1, 1'b1);
    close_req <= 1'b0;
    wt(2 * T);
    chk_out(1'b0, 1'b0, 1'b0);
    wr(`SGS_OFF_CTRL, 32'h0);
  endtask : t_input

  // Torque compare with delay restart, method gating and limited hysteresis
  task automatic t_torque;
    ctrl_method <= SGS_METHOD_VELOCITY;
    wr(`SGS_OFF_VEL_MODE, 32'h3);
    wr(`SGS_OFF_VEL_LEVEL, 32'd100);
    wr(`SGS_OFF_VEL_HYST, 32'd20);
    wr(`SGS_OFF_VEL_DELAY, 32'd3);
    torque_cmd <= 16'sd120;
    wt(2 * T);
    chk_out(1'b0, 1'b0, 1'b0);
    torque_cmd <= -16'sd121;
    wt(2 * T);
    chk_out(1'b1, 1'b0, 1'b1);
    torque_cmd <= -16'sd79;
    wt(2 * T);
    torque_cmd <= 16'sd80;
    wt(T);
    torque_cmd <= 16'sd0;
    wt(3 * T);
    chk_out(1'b1, 1'b0, 1'b1);
    wt(T + 2);
    chk_out(1'b0, 1'b0, 1'b0);
    ctrl_method <= SGS_METHOD_POSITION;
    torque_cmd <= 16'sd500;
    wt(2 * T);
    chk_out(1'b0, 1'b0, 1'b0);
    ctrl_method <= SGS_METHOD_VELOCITY;
    torque_cmd <= 16'sd20;
    wr(`SGS_OFF_VEL_LEVEL, 32'd10);
    wr(`SGS_OFF_VEL_HYST, 32'd50);
    rd_chk(`SGS_OFF_VEL_HEFF, 32'd10);
    wt(2 * T);
    chk_out(1'b0, 1'b0, 1'b0);
    torque_cmd <= 16'sd21;
    wt(2 * T);
    chk_out(1'b1, 1'b0, 1'b1);
    wr(`SGS_OFF_VEL_MODE, 32'h0);
    torque_cmd <= 16'sd0;
    wt(2 * T);
  endtask : t_torque

  // Speed command change compare, zero delay, forced first outside velocity
  task automatic t_rate;
    wr(`SGS_OFF_VEL_LEVEL, 32'd200);
    wr(`SGS_OFF_VEL_HYST, 32'd0);
    wr(`SGS_OFF_VEL_DELAY, 32'd0);
    wr(`SGS_OFF_VEL_MODE, 32'h4);
    speed_cmd_rate <= -16'sd201;
    wt(2 * T);
    chk_out(1'b1, 1'b0, 1'b1);
    speed_cmd_rate <= -16'sd199;
    wt(T + 2);
    chk_out(1'b0, 1'b0, 1'b0);
    speed_cmd_rate <= 16'sd300;
    ctrl_method <= SGS_METHOD_TORQUE;
    wt(2 * T);
    chk_out(1'b0, 1'b0, 1'b0);
  endtask : t_rate

  // Torque loop compare with its own delay
  task automatic t_trq;
    wr(`SGS_OFF_TRQ_MODE, 32'h3);
    wr(`SGS_OFF_TRQ_LEVEL, 32'd50);
    wr(`SGS_OFF_TRQ_HYST, 32'd5);
    wr(`SGS_OFF_TRQ_DELAY, 32'd2);
    torque_cmd <= 16'sd55;
    wt(2 * T);
    chk_out(1'b0, 1'b0, 1'b0);
    torque_cmd <= -16'sd56;
    wt(2 * T);
    chk_out(1'b0, 1'b1, 1'b1);
    torque_cmd <= 16'sd44;
    wt(2 * T);
    chk_out(1'b0, 1'b1, 1'b1);
    wt(T + 2);
    chk_out(1'b0, 1'b0, 1'b0);
  endtask : t_trq

  // Main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_modes();
    t_input();
    t_torque();
    t_rate();
    t_trq();
    print_verdict();
  end
endmodule : testbench
